/* verification/rfs_card_model.sv */
// far side model: card answering on the aux pin, plus field detector
`timescale 1ns/1ns
module rfs_card_model
(
   input wire logic clk,
   input wire logic drive,
   input wire logic level,
   input wire logic field,
   output logic aux_out,
   output logic field_out
);
   logic aux_q;
   // released pin toggles so a stale level never passes
   always_ff @(posedge clk)
   begin
      if (drive)
         aux_q <= level;
      else
         aux_q <= ~aux_q;
   end
   assign aux_out = aux_q;
   assign field_out = field;
endmodule

/* verification/rfs_frontend_assertions.sv */
// concurrent checks on the ports of the front end source select block
`timescale 1ns/1ns
module rfs_frontend_assertions
(
   input wire logic MCLK,
   input wire logic RST_N,
   input wire logic CYC_I,
   input wire logic STB_I,
   input wire logic ACK_O,
   input wire logic [31:0] DAT_O,
   input wire logic CMD_START,
   input wire logic CMD_RECV_ONLY,
   input wire logic RX_STOP,
   input wire logic RX_ACTIVE,
   input wire logic COLL_VALID,
   input wire logic DECODER_IN,
   input wire logic COLLISION,
   input wire logic DRV_A_OE_N,
   input wire logic DRV_B_OE_N
);
   default clocking cb @(posedge MCLK);
   endclocking
   default disable iff (!RST_N);
   // ----------------------------------------
   // sequences
   // ----------------------------------------
   sequence s_req;
      CYC_I && STB_I && !ACK_O;
   endsequence
   sequence s_recv_start;
      CMD_START && CMD_RECV_ONLY && !RX_STOP;
   endsequence
   // ----------------------------------------
   // properties
   // ----------------------------------------
   property p_ack;
      s_req |=> ACK_O ##1 !ACK_O;
   endproperty
   property p_upper;
      DAT_O[31:8] == 24'h0;
   endproperty
   property p_recv;
      s_recv_start |=> RX_ACTIVE;
   endproperty
   property p_stop;
      RX_STOP |=> !RX_ACTIVE;
   endproperty
   property p_hold;
      RX_ACTIVE && !RX_STOP |=> RX_ACTIVE;
   endproperty
   property p_dec;
      !RX_ACTIVE |=> !DECODER_IN;
   endproperty
   property p_coll;
      $rose(COLLISION) |-> $past(COLL_VALID) && $past(RX_ACTIVE);
   endproperty
   property p_oe;
      DRV_A_OE_N == DRV_B_OE_N;
   endproperty
   a_ack: assert property (p_ack)
      else $error("ack is not one pulse per request");
   a_upper: assert property (p_upper)
      else $error("upper read data not zero");
   a_recv: assert property (p_recv)
      else $error("receive-only start did not activate receiver");
   a_stop: assert property (p_stop)
      else $error("receiver still active after stop");
   a_hold: assert property (p_hold)
      else $error("receiver dropped without stop");
   a_dec: assert property (p_dec)
      else $error("decoder input moved while receiver idle");
   a_coll: assert property (p_coll)
      else $error("collision without valid amplitudes");
   a_oe: assert property (p_oe)
      else $error("driver enables differ");
endmodule

bind rfs_frontend rfs_frontend_assertions chk_u (
   .MCLK(MCLK),
   .RST_N(RST_N),
   .CYC_I(CYC_I),
   .STB_I(STB_I),
   .ACK_O(ACK_O),
   .DAT_O(DAT_O),
   .CMD_START(CMD_START),
   .CMD_RECV_ONLY(CMD_RECV_ONLY),
   .RX_STOP(RX_STOP),
   .RX_ACTIVE(RX_ACTIVE),
   .COLL_VALID(COLL_VALID),
   .DECODER_IN(DECODER_IN),
   .COLLISION(COLLISION),
   .DRV_A_OE_N(DRV_A_OE_N),
   .DRV_B_OE_N(DRV_B_OE_N)
);

/* verification/rfs_frontend_test.sv */
// self-checking bench for the front end source select block
`timescale 1ns/1ns
`include "rfs_defines.svh"
module rfs_frontend_test;
   import rfs_pkg::*;
   localparam logic [7:0] A_MOD = {`RFS_IDX_TX_MOD, 2'h0};
   localparam logic [7:0] A_SRC = {`RFS_IDX_TX_SRC, 2'h0};
   localparam logic [7:0] A_RXS = {`RFS_IDX_RX_SRC, 2'h0};
   localparam logic [7:0] A_THR = {`RFS_IDX_RX_THR, 2'h0};
   localparam logic [7:0] A_DRV = {`RFS_IDX_DRV_CTL, 2'h0};
   localparam logic [7:0] A_TST = {`RFS_IDX_TEST_SEL, 2'h0};
   localparam logic [17:0] AUX_EXP = 18'b100110010101010010;
   logic MCLK, RST_N, WE_I, STB_I, CYC_I, MILLER_ENV, TX_SERIAL, RX_DECODED;
   logic ANALOG_RX, SOFT_PWRDN, CMD_RECV_ONLY, drive_aux, aux_lvl, field_on;
   logic [7:0] ADR_I, TEST_BUS, WEAK_AMP, STRONG_AMP;
   logic [31:0] DAT_I;
   logic [3:0] SEL_I, SIG_STRENGTH;
   logic [4:0] strb;
   wire logic CMD_START, TX_DONE, RX_STOP, BIT_CLK_EN, COLL_VALID;
   wire logic AUX_MOD_IN, RF_FIELD_ON;
   wire logic [31:0] DAT_O;
   wire logic ACK_O, FULL_KEYING, DRV_A_O, DRV_A_OE_N, DRV_B_O, DRV_B_OE_N;
   wire logic AUX_OUT_O, AUX_OUT_OE_N, DECODER_IN, DECODER_NRZ;
   wire logic RX_ACTIVE, COLLISION;
   wire logic [3:0] drv;
   int bad_count, checks;
   rfs_byte_t rd;
   assign {CMD_START, TX_DONE, RX_STOP, BIT_CLK_EN, COLL_VALID} = strb;
   assign drv = {DRV_A_OE_N, DRV_A_O, DRV_B_OE_N, DRV_B_O};
   rfs_frontend #(.GUARD_W(6)) dut_u (.*);
   rfs_card_model card_u (.clk(MCLK), .drive(drive_aux), .level(aux_lvl),
      .field(field_on), .aux_out(AUX_MOD_IN), .field_out(RF_FIELD_ON));
   // ----------------------------------------
   // shared tasks
   // ----------------------------------------
   task chk(input logic [7:0] got, input logic [7:0] exp);
   begin
      checks++;
      if (got !== exp)
      begin
         bad_count++;
         $display("wrong value at %0t: got %h want %h", $time, got, exp);
      end
   end
   endtask
   task wb(input logic [7:0] a, input logic w, input rfs_byte_t d);
   begin
      @(posedge MCLK);
      {CYC_I, STB_I, WE_I, ADR_I, DAT_I} <= {2'h3, w, a, 24'h0, d};
      @(posedge MCLK);
      while (ACK_O !== 1'b1)
         @(posedge MCLK);
      rd = DAT_O[7:0];
      {CYC_I, STB_I} <= 2'h0;
   end
   endtask
   task rdchk(input logic [7:0] a, input rfs_byte_t exp);
   begin
      wb(a, 1'b0, 8'h00);
      chk(rd, exp);
   end
   endtask
   task settle;
   begin
      repeat (5) @(posedge MCLK);
      @(negedge MCLK);
   end
   endtask
   task pulse(input logic [4:0] m);
   begin
      @(posedge MCLK);
      strb <= m;
      @(posedge MCLK);
      strb <= 5'h0;
   end
   endtask
   task gcheck(input logic e);
   begin
      @(posedge MCLK);
      @(negedge MCLK);
      chk({7'h0, RX_ACTIVE}, {7'h0, e});
   end
   endtask
   task count3;
   begin
      pulse(5'h02);
      pulse(5'h02);
      gcheck(1'b0);
      pulse(5'h02);
      gcheck(1'b1);
   end
   endtask
   // ----------------------------------------
   // scenarios
   // ----------------------------------------
   task t_regs;
   begin
      rdchk(A_MOD, 8'h00);
      rdchk(A_SRC, 8'h10);
      rdchk(A_RXS, 8'h84);
      rdchk(A_THR, 8'h84);
      rdchk(8'hfc, 8'h00);
      wb(A_MOD, 1'b1, 8'hff);
      rdchk(A_MOD, 8'h40);
      chk({7'h0, FULL_KEYING}, 8'h01);
      wb(A_THR, 1'b1, 8'hff);
      rdchk(A_THR, 8'hf7);
   end
   endtask
   task t_drv;
   begin
      @(posedge MCLK);
      SOFT_PWRDN <= 1'b1;
      settle;
      chk({4'h0, drv}, 8'h05);
      wb(A_SRC, 1'b1, 8'h20);
      settle;
      chk({4'h0, drv}, 8'h00);
      wb(A_SRC, 1'b1, 8'h00);
      settle;
      chk({4'h0, drv & 4'ha}, 8'h0a);
      wb(A_SRC, 1'b1, 8'h30);
      wb(A_DRV, 1'b1, 8'h24);
      settle;
      chk({4'h0, drv}, 8'h04);
      wb(A_DRV, 1'b1, 8'h09);
      settle;
      chk({4'h0, drv}, 8'h05);
   end
   endtask
   task t_aux;
      int c;
   begin
      wb(A_TST, 1'b1, 8'h05);
      for (c = 0; c < 9; c++)
      begin
         wb(A_SRC, 1'b1, {4'h1, c[3:0]});
         settle;
         chk({6'h0, AUX_OUT_OE_N, AUX_OUT_O & ~AUX_OUT_OE_N},
            {6'h0, AUX_EXP[2*c+:2]});
      end
   end
   endtask
   task t_dec;
      int s;
      logic [7:0] e;
   begin
      e = 8'b11010100;
      @(posedge MCLK);
      {CMD_RECV_ONLY, aux_lvl, ANALOG_RX} <= 3'h7;
      pulse(5'h10);
      @(negedge MCLK);
      chk({7'h0, RX_ACTIVE}, 8'h01);
      for (s = 0; s < 4; s++)
      begin
         wb(A_RXS, 1'b1, {s[1:0], 6'h04});
         settle;
         chk({6'h0, DECODER_NRZ, DECODER_IN}, {6'h0, e[2*s+:2]});
      end
      wb(A_RXS, 1'b1, 8'h44);
      SIG_STRENGTH <= 4'he;
      settle;
      chk({7'h0, DECODER_IN}, 8'h00);
      wb(A_THR, 1'b1, 8'h84);
      for (s = 0; s < 2; s++)
      begin
         @(posedge MCLK);
         WEAK_AMP <= 8'h31 + s[7:0];
         pulse(5'h01);
         @(negedge MCLK);
         chk({7'h0, COLLISION}, s[7:0]);
      end
      pulse(5'h04);
   end
   endtask
   task t_guard;
   begin
      wb(A_RXS, 1'b1, 8'h43);
      CMD_RECV_ONLY <= 1'b0;
      pulse(5'h08);
      count3;
      pulse(5'h04);
      field_on <= 1'b1;
      repeat (5) @(posedge MCLK);
      count3;
   end
   endtask
   task results;
   begin
      if (bad_count == 0 && checks > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   end
   endtask
   // ----------------------------------------
   // clock, watchdog, main sequence
   // ----------------------------------------
   initial
   begin
      MCLK = 1'b0;
      forever #5 MCLK = ~MCLK;
   end
   initial
   begin
      #100000;
      bad_count++;
      results;
   end
   initial
   begin
      {CYC_I, STB_I, WE_I, TX_SERIAL, SOFT_PWRDN, CMD_RECV_ONLY} = 6'h04;
      {MILLER_ENV, RX_DECODED, drive_aux, aux_lvl, field_on} = 5'h1c;
      {ADR_I, TEST_BUS, WEAK_AMP, STRONG_AMP} = 32'h00200064;
      {DAT_I, SEL_I, SIG_STRENGTH, strb} = {32'h0, 4'h1, 4'hf, 5'h0};
      ANALOG_RX = 1'b0;
      RST_N = 1'b0;
      repeat (6) @(posedge MCLK);
      RST_N <= 1'b1;
      t_regs;
      t_drv;
      t_aux;
      t_dec;
      t_guard;
      results;
   end
endmodule

/* verilog/rfs_defines.svh */
// register offsets, field positions, codes and reset values
`ifndef RFS_DEFINES_SVH
`define RFS_DEFINES_SVH
// ----------------------------------------
// register indices (byte address = 4 * index)
// ----------------------------------------
`define RFS_IDX_TX_MOD 6'h15
`define RFS_IDX_TX_SRC 6'h16
`define RFS_IDX_RX_SRC 6'h17
`define RFS_IDX_RX_THR 6'h18
`define RFS_IDX_DRV_CTL 6'h20
`define RFS_IDX_TEST_SEL 6'h21
`define RFS_IDX_STATUS 6'h22
// ----------------------------------------
// reset values and writable bit masks
// ----------------------------------------
`define RFS_RST_TX_MOD 8'h00
`define RFS_RST_TX_SRC 8'h10
`define RFS_RST_RX_SRC 8'h84
`define RFS_RST_RX_THR 8'h84
`define RFS_RST_DRV_CTL 8'h00
`define RFS_RST_TEST_SEL 8'h00
`define RFS_MSK_TX_MOD 8'h40
`define RFS_MSK_TX_SRC 8'h3f
`define RFS_MSK_RX_SRC 8'hff
`define RFS_MSK_RX_THR 8'hf7
`define RFS_MSK_DRV_CTL 8'h3f
`define RFS_MSK_TEST_SEL 8'h07
// ----------------------------------------
// field positions
// ----------------------------------------
`define RFS_FORCE_BIT 6
`define RFS_DRV_SRC_HI 5
`define RFS_DRV_SRC_LO 4
`define RFS_AUX_SRC_HI 3
`define RFS_AUX_SRC_LO 0
`define RFS_DEC_SRC_HI 7
`define RFS_DEC_SRC_LO 6
`define RFS_GUARD_HI 5
`define RFS_GUARD_LO 0
`define RFS_MIN_HI 7
`define RFS_MIN_LO 4
`define RFS_COLL_HI 2
`define RFS_COLL_LO 0
`define RFS_TBSEL_HI 2
`define RFS_TBSEL_LO 0
`define RFS_DRV_A_EN 0
`define RFS_DRV_B_EN 1
`define RFS_A_INV_ON 2
`define RFS_A_INV_OFF 3
`define RFS_B_INV_ON 4
`define RFS_B_INV_OFF 5
// ----------------------------------------
// source codes
// ----------------------------------------
`define RFS_DRV_TRI 2'h0
`define RFS_DRV_MILLER 2'h1
`define RFS_DRV_AUXIN 2'h2
`define RFS_DRV_HIGH 2'h3
`define RFS_AUX_TRI 4'h0
`define RFS_AUX_LOW 4'h1
`define RFS_AUX_HIGH 4'h2
`define RFS_AUX_TEST 4'h3
`define RFS_AUX_MILLER 4'h4
`define RFS_AUX_SERIAL 4'h5
`define RFS_AUX_DECODED 4'h7
`define RFS_DEC_LOW 2'h0
`define RFS_DEC_MANCH 2'h1
`define RFS_DEC_ANALOG 2'h2
`define RFS_DEC_NRZ 2'h3
`endif

/* verilog/rfs_frontend.sv */
// front end source select registers, driver muxes and receive guard
//
// Local design decision: register access over Wishbone.
`timescale 1ns/1ns
`include "rfs_defines.svh"
// Behaviour
// - force-full-keying bit 6 set gives full keying regardless of conductance.
// - driver source 00 tri-state, 01 Miller, 10 aux input, 11 high.
// - soft power-down tri-states drivers only when source code is 00.
// - with code 11 each driver level comes from its inversion bits.
// - aux output codes: tri, low, high, Miller, pre-Miller, decoded stream.
// - aux code 0011 routes the test bus bit picked by selector.
// - decoder input 00 low, 01 Manchester aux input, 10 analog receiver.
// - decoder code 11 takes NRZ aux input; software uses above 106 kBd.
// - after transmit, receiver waits the six-bit guard count of bit-clocks.
// - receiver input is ignored while the guard delay runs.
// - receive-only command starts receiving without the guard delay.
// - all other commands apply the guard delay before reception.
// - guard counter also starts when an external field switches on.
// - decoder ignores input weaker than the four-bit minimum level.
// - collision only when weaker half-bit reaches level relative to stronger.
// - driver inverts by on-bit when enabled, by off-bit when disabled.
module rfs_frontend
#(
   parameter int GUARD_W = 6
)
(
   input wire logic MCLK,
   input wire logic RST_N,
   input wire logic [7:0] ADR_I,
   input wire logic [31:0] DAT_I,
   output logic [31:0] DAT_O,
   input wire logic WE_I,
   input wire logic [3:0] SEL_I,
   input wire logic STB_I,
   input wire logic CYC_I,
   output logic ACK_O,
   input wire logic MILLER_ENV,
   input wire logic TX_SERIAL,
   input wire logic RX_DECODED,
   input wire logic [7:0] TEST_BUS,
   input wire logic ANALOG_RX,
   input wire logic AUX_MOD_IN,
   input wire logic RF_FIELD_ON,
   input wire logic SOFT_PWRDN,
   input wire logic CMD_START,
   input wire logic CMD_RECV_ONLY,
   input wire logic TX_DONE,
   input wire logic RX_STOP,
   input wire logic BIT_CLK_EN,
   input wire logic [3:0] SIG_STRENGTH,
   input wire logic COLL_VALID,
   input wire logic [7:0] WEAK_AMP,
   input wire logic [7:0] STRONG_AMP,
   output logic FULL_KEYING,
   output logic DRV_A_O,
   output logic DRV_A_OE_N,
   output logic DRV_B_O,
   output logic DRV_B_OE_N,
   output logic AUX_OUT_O,
   output logic AUX_OUT_OE_N,
   output logic DECODER_IN,
   output logic DECODER_NRZ,
   output logic RX_ACTIVE,
   output logic COLLISION
);
   import rfs_pkg::*;

   // ----------------------------------------
   // register storage
   // ----------------------------------------
   rfs_byte_t tx_mod_q;
   rfs_byte_t tx_src_q;
   rfs_byte_t rx_src_q;
   rfs_byte_t rx_thr_q;
   rfs_byte_t drv_ctl_q;
   rfs_byte_t test_sel_q;
   logic ack_q;
   logic [5:0] idx;
   logic wr_en;
   rfs_byte_t rd_d;
   rfs_byte_t status;

   // ----------------------------------------
   // pin synchronisers
   // ----------------------------------------
   logic aux_in_m_q;
   logic aux_in_q;
   logic field_m_q;
   logic field_q;
   logic field_prev_q;
   logic field_rise;

   always_ff @(posedge MCLK or negedge RST_N)
   begin
      if (!RST_N)
      begin
         aux_in_m_q <= 1'b0;
         aux_in_q <= 1'b0;
         field_m_q <= 1'b0;
         field_q <= 1'b0;
         field_prev_q <= 1'b0;
      end
      else
      begin
         aux_in_m_q <= AUX_MOD_IN;
         aux_in_q <= aux_in_m_q;
         field_m_q <= RF_FIELD_ON;
         field_q <= field_m_q;
         field_prev_q <= field_q;
      end
   end
   assign field_rise = field_q & ~field_prev_q;

   // ----------------------------------------
   // wishbone slave, one wait state
   // ----------------------------------------
   assign idx = ADR_I[7:2];
   assign wr_en = CYC_I & STB_I & WE_I & SEL_I[0] & ack_q;

   always_ff @(posedge MCLK or negedge RST_N)
   begin
      if (!RST_N)
         ack_q <= 1'b0;
      else
         ack_q <= CYC_I & STB_I & ~ack_q;
   end
   assign ACK_O = ack_q;

   // writes land at the ack edge, reserved bits kept zero
   always_ff @(posedge MCLK or negedge RST_N)
   begin
      if (!RST_N)
      begin
         tx_mod_q <= `RFS_RST_TX_MOD;
         tx_src_q <= `RFS_RST_TX_SRC;
         rx_src_q <= `RFS_RST_RX_SRC;
         rx_thr_q <= `RFS_RST_RX_THR;
         drv_ctl_q <= `RFS_RST_DRV_CTL;
         test_sel_q <= `RFS_RST_TEST_SEL;
      end
      else if (wr_en)
      begin
         case (idx)
            `RFS_IDX_TX_MOD: tx_mod_q <= DAT_I[7:0] & `RFS_MSK_TX_MOD;
            `RFS_IDX_TX_SRC: tx_src_q <= DAT_I[7:0] & `RFS_MSK_TX_SRC;
            `RFS_IDX_RX_SRC: rx_src_q <= DAT_I[7:0] & `RFS_MSK_RX_SRC;
            `RFS_IDX_RX_THR: rx_thr_q <= DAT_I[7:0] & `RFS_MSK_RX_THR;
            `RFS_IDX_DRV_CTL: drv_ctl_q <= DAT_I[7:0] & `RFS_MSK_DRV_CTL;
            `RFS_IDX_TEST_SEL: test_sel_q <= DAT_I[7:0] & `RFS_MSK_TEST_SEL;
            default: ;
         endcase
      end
   end

   always_comb
   begin
      case (idx)
         `RFS_IDX_TX_MOD: rd_d = tx_mod_q;
         `RFS_IDX_TX_SRC: rd_d = tx_src_q;
         `RFS_IDX_RX_SRC: rd_d = rx_src_q;
         `RFS_IDX_RX_THR: rd_d = rx_thr_q;
         `RFS_IDX_DRV_CTL: rd_d = drv_ctl_q;
         `RFS_IDX_TEST_SEL: rd_d = test_sel_q;
         `RFS_IDX_STATUS: rd_d = status;
         default: rd_d = 8'h00;
      endcase
   end

   always_ff @(posedge MCLK or negedge RST_N)
   begin
      if (!RST_N)
         DAT_O <= 32'h0000_0000;
      else if (CYC_I & STB_I & ~ack_q & ~WE_I)
         DAT_O <= {24'h00_0000, rd_d};
   end

   // ----------------------------------------
   // field views
   // ----------------------------------------
   logic [1:0] drv_src;
   logic [3:0] aux_src;
   logic [1:0] dec_src;
   logic [GUARD_W-1:0] guard_cnt;
   logic [3:0] min_level;
   logic [2:0] coll_level;
   logic [2:0] tb_sel;

   assign drv_src = tx_src_q[`RFS_DRV_SRC_HI:`RFS_DRV_SRC_LO];
   assign aux_src = tx_src_q[`RFS_AUX_SRC_HI:`RFS_AUX_SRC_LO];
   assign dec_src = rx_src_q[`RFS_DEC_SRC_HI:`RFS_DEC_SRC_LO];
   assign guard_cnt = rx_src_q[`RFS_GUARD_HI:`RFS_GUARD_LO];
   assign min_level = rx_thr_q[`RFS_MIN_HI:`RFS_MIN_LO];
   assign coll_level = rx_thr_q[`RFS_COLL_HI:`RFS_COLL_LO];
   assign tb_sel = test_sel_q[`RFS_TBSEL_HI:`RFS_TBSEL_LO];

   // ----------------------------------------
   // antenna drivers
   // ----------------------------------------
   logic drv_raw;
   logic a_inv;
   logic b_inv;

   // power-down does not tri-state unless code is tri
   always_comb
   begin
      case (drv_src)
         `RFS_DRV_MILLER: drv_raw = MILLER_ENV;
         `RFS_DRV_AUXIN: drv_raw = aux_in_q;
         `RFS_DRV_HIGH: drv_raw = 1'b1;
         default: drv_raw = 1'b0;
      endcase
   end

   assign a_inv = drv_ctl_q[`RFS_DRV_A_EN] ? drv_ctl_q[`RFS_A_INV_ON]
                                           : drv_ctl_q[`RFS_A_INV_OFF];
   assign b_inv = drv_ctl_q[`RFS_DRV_B_EN] ? drv_ctl_q[`RFS_B_INV_ON]
                                           : drv_ctl_q[`RFS_B_INV_OFF];

   always_ff @(posedge MCLK or negedge RST_N)
   begin
      if (!RST_N)
      begin
         DRV_A_O <= 1'b0;
         DRV_B_O <= 1'b0;
         DRV_A_OE_N <= 1'b1;
         DRV_B_OE_N <= 1'b1;
         FULL_KEYING <= 1'b0;
      end
      else
      begin
         DRV_A_O <= drv_raw ^ a_inv;
         DRV_B_O <= drv_raw ^ b_inv;
         DRV_A_OE_N <= (drv_src == `RFS_DRV_TRI);
         DRV_B_OE_N <= (drv_src == `RFS_DRV_TRI);
         FULL_KEYING <= tx_mod_q[`RFS_FORCE_BIT];
      end
   end

   // ----------------------------------------
   // auxiliary output pin
   // ----------------------------------------
   logic aux_d;
   logic aux_oe_n_d;

   always_comb
   begin
      aux_oe_n_d = 1'b0;
      case (aux_src)
         `RFS_AUX_LOW: aux_d = 1'b0;
         `RFS_AUX_HIGH: aux_d = 1'b1;
         `RFS_AUX_TEST: aux_d = TEST_BUS[tb_sel];
         `RFS_AUX_MILLER: aux_d = MILLER_ENV;
         `RFS_AUX_SERIAL: aux_d = TX_SERIAL;
         `RFS_AUX_DECODED: aux_d = RX_DECODED;
         default:
         begin
            aux_d = 1'b0;
            aux_oe_n_d = 1'b1;
         end
      endcase
   end

   always_ff @(posedge MCLK or negedge RST_N)
   begin
      if (!RST_N)
      begin
         AUX_OUT_O <= 1'b0;
         AUX_OUT_OE_N <= 1'b1;
      end
      else
      begin
         AUX_OUT_O <= aux_d;
         AUX_OUT_OE_N <= aux_oe_n_d;
      end
   end

   // ----------------------------------------
   // receive guard sequencer
   // ----------------------------------------
   rfs_rx_state_t state_q;
   logic [GUARD_W-1:0] cnt_q;
   logic guard_start;

   // every command but receive-only waits the guard
   assign guard_start = (TX_DONE & ~CMD_RECV_ONLY) | field_rise;

   always_ff @(posedge MCLK or negedge RST_N)
   begin
      if (!RST_N)
      begin
         state_q <= RFS_IDLE;
         cnt_q <= '0;
      end
      else if (RX_STOP)
         state_q <= RFS_IDLE;
      else if (CMD_START & CMD_RECV_ONLY)
         state_q <= RFS_RECV;
      else if (guard_start)
      begin
         cnt_q <= guard_cnt;
         state_q <= (guard_cnt == '0) ? RFS_RECV : RFS_GUARD;
      end
      else
      begin
         case (state_q)
            RFS_GUARD:
            begin
               if (BIT_CLK_EN)
               begin
                  cnt_q <= cnt_q - 1'b1;
                  if (cnt_q == {{(GUARD_W-1){1'b0}}, 1'b1})
                     state_q <= RFS_RECV;
               end
            end
            RFS_RECV: ;
            RFS_IDLE: ;
            default: state_q <= RFS_IDLE;
         endcase
      end
   end

   assign RX_ACTIVE = (state_q == RFS_RECV);

   // ----------------------------------------
   // decoder input and thresholds
   // ----------------------------------------
   logic dec_raw;
   logic strong_ok;
   logic [10:0] weak_scaled;
   logic [10:0] strong_scaled;

   always_comb
   begin
      case (dec_src)
         `RFS_DEC_MANCH: dec_raw = aux_in_q;
         `RFS_DEC_ANALOG: dec_raw = ANALOG_RX;
         `RFS_DEC_NRZ: dec_raw = aux_in_q;
         default: dec_raw = 1'b0;
      endcase
   end

   assign strong_ok = (SIG_STRENGTH >= min_level);
   assign weak_scaled = {WEAK_AMP, 3'h0};
   assign strong_scaled = STRONG_AMP * coll_level;

   always_ff @(posedge MCLK or negedge RST_N)
   begin
      if (!RST_N)
      begin
         DECODER_IN <= 1'b0;
         DECODER_NRZ <= 1'b0;
         COLLISION <= 1'b0;
      end
      else
      begin
         // guard time and weak input both blank the decoder
         DECODER_IN <= dec_raw & RX_ACTIVE & strong_ok;
         DECODER_NRZ <= (dec_src == `RFS_DEC_NRZ);
         COLLISION <= COLL_VALID & RX_ACTIVE & strong_ok &
                      (weak_scaled >= strong_scaled);
      end
   end

   // ----------------------------------------
   // status view
   // ----------------------------------------
   assign status = {4'h0, field_q, COLLISION,
                    state_q == RFS_GUARD, RX_ACTIVE};
endmodule

/* verilog/rfs_pkg.sv */
// shared types of the front end source select block
package rfs_pkg;
   typedef logic [7:0] rfs_byte_t;
   typedef enum logic [1:0] {RFS_IDLE, RFS_GUARD, RFS_RECV} rfs_rx_state_t;
endpackage
